//--- include/ipc_pkg.sv
// Constants for the I/O port pin input-control block, with the contract list.
// Contract
// - Analog-selected pin reads back as zero digitally.
// - Analog select leaves digital output drive untouched.
// - Port read-modify-write may corrupt analog pins' latch.
// - Analog select bits reset to analog mode.
// - Output comes from port latch after reset.
// - Threshold select feeds port read and change detect.
// - Each pin has its own weak pull-up enable.
package ipc_pkg;
    localparam int IPC_PINS = 8;
    localparam int IPC_ADDR_W = 8;
    localparam logic [IPC_ADDR_W-1:0] IPC_OFS_PORT = 8'h00;
    localparam logic [IPC_ADDR_W-1:0] IPC_OFS_LATCH = 8'h04;
    localparam logic [IPC_ADDR_W-1:0] IPC_OFS_DIR = 8'h08;
    localparam logic [IPC_ADDR_W-1:0] IPC_OFS_ANALOG = 8'h0C;
    localparam logic [IPC_ADDR_W-1:0] IPC_OFS_THRESH = 8'h10;
    localparam logic [IPC_ADDR_W-1:0] IPC_OFS_PULLUP = 8'h14;
    localparam logic [IPC_ADDR_W-1:0] IPC_OFS_ROUTE = 8'h18;
    localparam logic [7:0] IPC_RST_LATCH = 8'h00;
    localparam logic [7:0] IPC_RST_DIR = 8'hFF;
    localparam logic [7:0] IPC_RST_ANALOG = 8'hFF;
    localparam logic [7:0] IPC_RST_THRESH = 8'hFF;
    localparam logic [7:0] IPC_RST_PULLUP = 8'h00;
    localparam logic [7:0] IPC_RST_ROUTE = 8'h00;
    localparam logic [31:0] IPC_ZERO_WORD = 32'h0000_0000;
endpackage

//--- include/ipc_in_if.sv
// Carrier between the register side and the per-pin input path.
`timescale 1ns/10ps
interface ipc_in_if;
    logic [7:0] analogSel;
    logic [7:0] schmittSel;
    logic [7:0] schmittLevel;
    logic [7:0] ttlLevel;
    logic [7:0] digIn;
    modport ctrl (output analogSel, output schmittSel, output schmittLevel, output ttlLevel,
        input digIn);
    modport path (input analogSel, input schmittSel, input schmittLevel, input ttlLevel,
        output digIn);
endinterface

//--- rtl/ipc_input_path.sv
// Per-pin digital input path: threshold choice and analog masking.
`timescale 1ns/10ps
module ipc_input_path
    import ipc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    ipc_in_if.path pins
);
    logic [7:0] digIn_reg;
    logic [7:0] digIn_next;

    genvar i;
    generate
        for (i = 0; i < IPC_PINS; i++)
        begin : g_pin
            always_comb
            begin
                if (pins.analogSel[i])
                begin
                    digIn_next[i] = 1'b0;
                end
                else
                begin
                    digIn_next[i] = pins.schmittSel[i] ? pins.schmittLevel[i]
                                                       : pins.ttlLevel[i];
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            digIn_reg <= 8'h00;
        end
        else
        begin
            digIn_reg <= digIn_next;
        end
    end

    assign pins.digIn = digIn_reg;

    analog_reads_zero_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        ($past(pins.analogSel) != 8'h00) |-> ((pins.digIn & $past(pins.analogSel)) == 8'h00))
        else $error("Analog pin read as one.");
    thresh_pick_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        1'b1 |=> (pins.digIn == (~$past(pins.analogSel) &
            (($past(pins.schmittSel) & $past(pins.schmittLevel)) |
             (~$past(pins.schmittSel) & $past(pins.ttlLevel))))))
        else $error("Input level ignores threshold choice.");
    ttl_used_c: cover property (@(posedge ref_clk) disable iff (!nrst)
        (pins.schmittSel == 8'h00) && (pins.analogSel == 8'h00) ##1 (pins.digIn != 8'h00));
endmodule

//--- rtl/ipc_port_ctrl.sv
// I/O port pin control: APB registers, output mux and input read path.
`timescale 1ns/10ps
module ipc_port_ctrl
    import ipc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [IPC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] pinSchmittLevel,
    input wire logic [7:0] pinTtlLevel,
    input wire logic [7:0] periphOut,
    output logic [7:0] pinOut,
    output logic [7:0] pinOeN,
    output logic [7:0] pinWeakPullupEnable,
    output logic [7:0] pinAnalogSelect,
    output logic [7:0] changeDetectLevel
);
    logic [7:0] latch_reg, latch_next;
    logic [7:0] dir_reg, dir_next;
    logic [7:0] analog_reg, analog_next;
    logic [7:0] thresh_reg, thresh_next;
    logic [7:0] pullup_reg, pullup_next;
    logic [7:0] route_reg, route_next;
    logic [31:0] rdata_reg, rdata_next;
    logic err_reg, err_next;
    logic [7:0] out_reg, out_next;
    logic [7:0] oeN_reg, oeN_next;
    logic setup, wrAccess, hit;

    ipc_in_if inPath ();

    assign inPath.analogSel = analog_reg;
    assign inPath.schmittSel = thresh_reg;
    assign inPath.schmittLevel = pinSchmittLevel;
    assign inPath.ttlLevel = pinTtlLevel;

    ipc_input_path u_path (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .pins(inPath.path)
    );

    assign setup = psel && !penable;
    assign wrAccess = psel && penable && pwrite && pstrb[0] && !err_reg;
    assign pready = psel && penable;
    assign pslverr = psel && penable && err_reg;

    // Read data is prepared in the setup cycle so prdata comes from a flop
    // and the access phase still completes without wait states.
    always_comb
    begin
        rdata_next = rdata_reg;
        err_next = err_reg;
        hit = 1'b1;
        if (setup)
        begin
            rdata_next = IPC_ZERO_WORD;
            if (paddr == IPC_OFS_PORT)
            begin
                // The live select masks again, so a read right after a pin turns analog
                // cannot show the level that the input flop caught one cycle earlier.
                rdata_next[7:0] = inPath.digIn & ~analog_reg;
            end
            else if (paddr == IPC_OFS_LATCH)
            begin
                rdata_next[7:0] = latch_reg;
            end
            else if (paddr == IPC_OFS_DIR)
            begin
                rdata_next[7:0] = dir_reg;
            end
            else if (paddr == IPC_OFS_ANALOG)
            begin
                rdata_next[7:0] = analog_reg;
            end
            else if (paddr == IPC_OFS_THRESH)
            begin
                rdata_next[7:0] = thresh_reg;
            end
            else if (paddr == IPC_OFS_PULLUP)
            begin
                rdata_next[7:0] = pullup_reg;
            end
            else if (paddr == IPC_OFS_ROUTE)
            begin
                rdata_next[7:0] = route_reg;
            end
            else
            begin
                hit = 1'b0;
            end
            err_next = !hit;
        end
    end

    always_comb
    begin
        latch_next = latch_reg;
        dir_next = dir_reg;
        analog_next = analog_reg;
        thresh_next = thresh_reg;
        pullup_next = pullup_reg;
        route_next = route_reg;
        if (wrAccess)
        begin
            // A write to the port offset lands in the latch, so a read-modify-write
            // copies zeros from analog pins back into their latch bits.
            if (paddr == IPC_OFS_PORT || paddr == IPC_OFS_LATCH)
            begin
                latch_next = pwdata[7:0];
            end
            else if (paddr == IPC_OFS_DIR)
            begin
                dir_next = pwdata[7:0];
            end
            else if (paddr == IPC_OFS_ANALOG)
            begin
                analog_next = pwdata[7:0];
            end
            else if (paddr == IPC_OFS_THRESH)
            begin
                thresh_next = pwdata[7:0];
            end
            else if (paddr == IPC_OFS_PULLUP)
            begin
                pullup_next = pwdata[7:0];
            end
            else if (paddr == IPC_OFS_ROUTE)
            begin
                route_next = pwdata[7:0];
            end
        end
    end

    always_comb
    begin
        // Analog select is deliberately absent here.
        out_next = (route_reg & periphOut) | (~route_reg & latch_reg);
        oeN_next = dir_reg;
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            latch_reg <= IPC_RST_LATCH;
            dir_reg <= IPC_RST_DIR;
            analog_reg <= IPC_RST_ANALOG;
            thresh_reg <= IPC_RST_THRESH;
            pullup_reg <= IPC_RST_PULLUP;
            route_reg <= IPC_RST_ROUTE;
            rdata_reg <= IPC_ZERO_WORD;
            err_reg <= 1'b0;
            out_reg <= IPC_RST_LATCH;
            oeN_reg <= IPC_RST_DIR;
        end
        else
        begin
            latch_reg <= latch_next;
            dir_reg <= dir_next;
            analog_reg <= analog_next;
            thresh_reg <= thresh_next;
            pullup_reg <= pullup_next;
            route_reg <= route_next;
            rdata_reg <= rdata_next;
            err_reg <= err_next;
            out_reg <= out_next;
            oeN_reg <= oeN_next;
        end
    end

    assign prdata = rdata_reg;
    assign pinOut = out_reg;
    assign pinOeN = oeN_reg;
    assign pinWeakPullupEnable = pullup_reg;
    assign pinAnalogSelect = analog_reg;
    assign changeDetectLevel = inPath.digIn;

    out_ignores_analog_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        ##1 1'b1 |=> (pinOut == (($past(route_reg) & $past(periphOut)) |
            (~$past(route_reg) & $past(latch_reg)))))
        else $error("Output value not from latch or route.");
    rmw_latch_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (wrAccess && paddr == IPC_OFS_PORT) |=> (latch_reg == $past(pwdata[7:0])))
        else $error("Port write missed the latch.");
    analog_reset_a: assert property (@(posedge ref_clk)
        $rose(nrst) |-> (analog_reg == IPC_RST_ANALOG))
        else $error("Analog select not set after reset.");
    latch_drive_rst_a: assert property (@(posedge ref_clk)
        $rose(nrst) |-> (route_reg == 8'h00) ##1 (pinOut == latch_reg))
        else $error("Output not from latch after reset.");
    change_level_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (changeDetectLevel & analog_reg & $past(analog_reg)) == 8'h00)
        else $error("Change detect sees analog pin high.");
    pullup_write_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (wrAccess && paddr == IPC_OFS_PULLUP) |=> (pinWeakPullupEnable == $past(pwdata[7:0])))
        else $error("Pull-up enable did not follow write.");
    reg_readback_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (setup && paddr == IPC_OFS_THRESH) ##1 (pready && !pwrite) |-> (prdata[7:0] == thresh_reg))
        else $error("Threshold register read mismatch.");
    port_read_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (setup && paddr == IPC_OFS_PORT) |=> ((prdata[7:0] & $past(analog_reg)) == 8'h00))
        else $error("Port read shows analog pin high.");
    bad_addr_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (setup && paddr > IPC_OFS_ROUTE) |=> (pready && pslverr))
        else $error("Unmapped access not flagged.");
    write_cov_c: cover property (@(posedge ref_clk) disable iff (!nrst)
        wrAccess && paddr == IPC_OFS_ANALOG && pwdata[7:0] == 8'h00);
    rmw_cov_c: cover property (@(posedge ref_clk) disable iff (!nrst)
        pready && !pwrite && paddr == IPC_OFS_PORT ##[1:4] wrAccess && paddr == IPC_OFS_PORT);
    route_cov_c: cover property (@(posedge ref_clk) disable iff (!nrst)
        route_reg != 8'h00 && pinOeN != 8'hFF);
endmodule

//--- dv/ipc_pin_model.sv
// Model of the pads and the peripheral output pins around the port block.
`timescale 1ns/10ps
module ipc_pin_model
    import ipc_pkg::*;
(
    input wire logic [7:0] pinOut,
    input wire logic [7:0] pinOeN,
    input wire logic [7:0] pinWeakPullupEnable,
    input wire logic [7:0] extLevel,
    input wire logic [7:0] midLevel,
    input wire logic [7:0] periphPattern,
    output logic [7:0] pinSchmittLevel,
    output logic [7:0] pinTtlLevel,
    output logic [7:0] periphOut
);
    logic [7:0] pad;
    // A driven pin shows its own output; an undriven one is pulled up or follows the outside.
    assign pad = (~pinOeN & pinOut) | (pinOeN & (pinWeakPullupEnable | extLevel));
    // A mid-rail pin looks high to the TTL comparator and low to the Schmitt one.
    assign pinSchmittLevel = pad & ~midLevel;
    assign pinTtlLevel = pad | midLevel;
    assign periphOut = periphPattern;
endmodule

//--- dv/testbench.sv
// Self-checking bench for the port pin control block.
`timescale 1ns/10ps
module testbench;
    import ipc_pkg::*;
    logic ref_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, rerr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'hF;
    logic [7:0] pinSchmittLevel, pinTtlLevel, periphOut, pinOut, pinOeN;
    logic [7:0] pinWeakPullupEnable, pinAnalogSelect, changeDetectLevel;
    logic [7:0] extLevel = 8'h00, midLevel = 8'h00, periphPattern = 8'h00;
    int num_errors = 0, total_checks = 0, cycles = 0;
    always #2.5 ref_clk = ~ref_clk;
    ipc_port_ctrl uut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pinSchmittLevel(pinSchmittLevel),
        .pinTtlLevel(pinTtlLevel), .periphOut(periphOut), .pinOut(pinOut), .pinOeN(pinOeN),
        .pinWeakPullupEnable(pinWeakPullupEnable), .pinAnalogSelect(pinAnalogSelect),
        .changeDetectLevel(changeDetectLevel));
    ipc_pin_model pads (.pinOut(pinOut), .pinOeN(pinOeN),
        .pinWeakPullupEnable(pinWeakPullupEnable), .extLevel(extLevel), .midLevel(midLevel),
        .periphPattern(periphPattern), .pinSchmittLevel(pinSchmittLevel),
        .pinTtlLevel(pinTtlLevel), .periphOut(periphOut));
    task summarize;
        $display("Errors %0d, checks %0d", num_errors, total_checks);
        if (num_errors == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
            num_errors++;
        end
    endtask
    // The request is held until pready is seen high; nothing is assumed about wait states.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        chk(rd, {24'h0, exp}, what);
    endtask
    task settle;
        repeat (3) @(posedge ref_clk);
    endtask
    task t_reset;
        rdchk(IPC_OFS_ANALOG, 8'hFF, "analog reset");
        rdchk(IPC_OFS_DIR, 8'hFF, "dir reset");
        rdchk(IPC_OFS_THRESH, 8'hFF, "thresh reset");
        rdchk(IPC_OFS_PULLUP, 8'h00, "pullup reset");
        rdchk(IPC_OFS_ROUTE, 8'h00, "route reset");
        chk({24'h0, pinAnalogSelect}, 32'hFF, "analog pins");
        chk({24'h0, pinOut}, 32'h00, "out reset");
        chk({24'h0, pinOeN}, 32'hFF, "drive off at reset");
    endtask
    task t_analog;
        extLevel <= 8'hFF;
        settle;
        rdchk(IPC_OFS_PORT, 8'h00, "analog read");
        apb(1'b1, IPC_OFS_ANALOG, 32'h0);
        settle;
        rdchk(IPC_OFS_PORT, 8'hFF, "digital read");
        chk({24'h0, changeDetectLevel}, 32'hFF, "change level");
    endtask
    task t_thresh;
        extLevel <= 8'h00;
        midLevel <= 8'h0F;
        settle;
        rdchk(IPC_OFS_PORT, 8'h00, "schmitt read");
        // No pin is routed to a peripheral yet, so switching thresholds cannot upset one.
        apb(1'b1, IPC_OFS_THRESH, 32'h0);
        settle;
        rdchk(IPC_OFS_PORT, 8'h0F, "ttl read");
        chk({24'h0, changeDetectLevel}, 32'h0F, "ttl change");
    endtask
    task t_output;
        apb(1'b1, IPC_OFS_ANALOG, 32'hFF);
        apb(1'b1, IPC_OFS_LATCH, 32'hA5);
        apb(1'b1, IPC_OFS_DIR, 32'h00);
        periphPattern <= 8'h3C;
        settle;
        chk({24'h0, pinOut}, 32'hA5, "analog out");
        chk({24'h0, pinOeN}, 32'h00, "drive on");
        apb(1'b1, IPC_OFS_ROUTE, 32'h0F);
        settle;
        chk({24'h0, pinOut}, 32'hAC, "routed out");
    endtask
    task t_rmw;
        apb(1'b1, IPC_OFS_ROUTE, 32'h0);
        apb(1'b1, IPC_OFS_ANALOG, 32'h0F);
        apb(1'b1, IPC_OFS_LATCH, 32'hFF);
        settle;
        rdchk(IPC_OFS_PORT, 8'hF0, "rmw read");
        apb(1'b1, IPC_OFS_PORT, rd);
        rdchk(IPC_OFS_LATCH, 8'hF0, "rmw latch");
    endtask
    task t_pullup;
        apb(1'b1, IPC_OFS_DIR, 32'hFF);
        apb(1'b1, IPC_OFS_ANALOG, 32'h0);
        midLevel <= 8'h00;
        apb(1'b1, IPC_OFS_PULLUP, 32'h55);
        pstrb <= 4'h0;
        apb(1'b1, IPC_OFS_PULLUP, 32'hAA);
        pstrb <= 4'hF;
        settle;
        chk({24'h0, pinWeakPullupEnable}, 32'h55, "pullup pins");
        rdchk(IPC_OFS_PORT, 8'h55, "pullup read");
        apb(1'b0, 8'h1C, 32'h0);
        chk({31'h0, rerr}, 32'h1, "unmapped error");
        chk(rd, 32'h0, "unmapped data");
    endtask
    task t_rereset;
        nrst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        rdchk(IPC_OFS_ANALOG, 8'hFF, "analog re-reset");
        rdchk(IPC_OFS_LATCH, 8'h00, "latch re-reset");
        chk({24'h0, pinOut}, 32'h00, "out re-reset");
    endtask
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            $display("MISMATCH at %0t: timeout", $time);
            num_errors++;
            summarize;
        end
    end
    initial
    begin
        repeat (20) @(posedge ref_clk);
        nrst <= 1'b1;
        t_reset;
        t_analog;
        t_thresh;
        t_output;
        t_rmw;
        t_pullup;
        t_rereset;
        summarize;
    end
endmodule
